// *** hpb_host_model.sv ***
// host processor model: strobes, address, fifo select and write data
`timescale 1ns/1ps
module hpb_host_model (
    input wire logic clock,
    output logic host_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic fifo_sel,
    output logic [hpb_pkg::HPB_ADDR_W-1:0] host_addr,
    output logic [hpb_pkg::HPB_DATA_W-1:0] host_data_in
);
    import hpb_pkg::*;
    // idle bus: all strobes high
    initial begin
        host_select_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        fifo_sel = 1'b0;
        host_addr = 7'h00;
        host_data_in = 16'h0000;
    end
    // open a frame; fifo select moves together with the address
    task automatic start(input logic wr, input logic fs, input logic [6:0] a, input logic [15:0] d);
        @(negedge clock);
        fifo_sel = fs;
        host_addr = a;
        host_data_in = d;
        host_select_n = 1'b0;
        read_strobe_n = wr;
        write_strobe_n = !wr;
        repeat (8) @(negedge clock);
    endtask : start
    // next word of a burst, spaced well past the sync delay
    task automatic next_addr(input logic [6:0] a);
        host_addr = a;
        repeat (8) @(negedge clock);
    endtask : next_addr
    // end by one strobe; write data held until the sync stages see the rise
    task automatic stop(input logic by_sel);
        host_select_n = host_select_n | by_sel;
        read_strobe_n = read_strobe_n | !by_sel;
        write_strobe_n = write_strobe_n | !by_sel;
        repeat (5) @(negedge clock);
        host_data_in = ~host_data_in; // released: the old word is gone
        host_select_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        repeat (4) @(negedge clock);
    endtask : stop
endmodule : hpb_host_model

// *** hpb_pkg.sv ***
// shared constants and types for the host parallel bus port
package hpb_pkg;
    localparam int HPB_DATA_W = 16;
    localparam int HPB_ADDR_W = 7;
    localparam int HPB_CSR_IDX_W = 5;
    localparam int HPB_FIFO_IDX_W = 2;
    localparam logic [4:0] HPB_BURST_MAX = 5'h10;
    localparam int HPB_CLK_MHZ = 25;
    localparam int HPB_DEASSERT_NS = 13;
    localparam int HPB_DEASSERT_CYC =
        ((HPB_DEASSERT_NS * HPB_CLK_MHZ + 999) / 1000 < 1) ? 1 : (HPB_DEASSERT_NS * HPB_CLK_MHZ + 999) / 1000;
    localparam int HPB_SYNC_STAGES = 3;
    localparam logic [15:0] HPB_DATA_RST = 16'h0000;
    localparam logic [6:0] HPB_ADDR_RST = 7'h00;
    localparam logic [4:0] HPB_COUNT_RST = 5'h00;
    typedef enum logic [1:0] {
        HPB_IDLE = 2'b00,
        HPB_READ = 2'b01,
        HPB_WRITE = 2'b10,
        HPB_GAP = 2'b11
    } hpb_state_t;
endpackage : hpb_pkg

// *** hpb_port.sv ***
`timescale 1ns/1ps
// host parallel bus port: single/burst reads, writes, fifo-direct routing

module hpb_port (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic host_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic fifo_sel,
    input wire logic [hpb_pkg::HPB_ADDR_W-1:0] host_addr,
    input wire logic [hpb_pkg::HPB_DATA_W-1:0] host_data_in,
    output logic [hpb_pkg::HPB_DATA_W-1:0] host_data_out,
    output logic host_data_oe,
    output logic [hpb_pkg::HPB_CSR_IDX_W-1:0] csr_index,
    output logic csr_rd_req,
    output logic csr_wr_req,
    output logic [hpb_pkg::HPB_DATA_W-1:0] csr_wr_data,
    output logic counter_snap,
    input wire logic [hpb_pkg::HPB_DATA_W-1:0] csr_rd_data,
    output logic rx_fifo_pop,
    output logic [hpb_pkg::HPB_FIFO_IDX_W-1:0] fifo_index,
    input wire logic [hpb_pkg::HPB_DATA_W-1:0] rx_fifo_data,
    output logic tx_fifo_push,
    output logic [hpb_pkg::HPB_DATA_W-1:0] tx_fifo_data,
    output logic burst_overrun
);
    import hpb_pkg::*;

    logic cs_n_s;
    logic rd_n_s;
    logic wr_n_s;
    logic fsel_s;
    hpb_state_t state;
    hpb_state_t next_state;
    logic [HPB_ADDR_W-1:0] cur_addr;
    logic [HPB_ADDR_W-1:0] next_cur_addr;
    logic [HPB_DATA_W-1:0] wr_hold;
    logic [HPB_DATA_W-1:0] next_wr_hold;
    logic [4:0] word_count;
    logic [4:0] next_word_count;
    logic is_fifo;
    logic next_is_fifo;
    logic [HPB_DATA_W-1:0] next_data_out;
    logic next_data_oe;
    logic [HPB_CSR_IDX_W-1:0] next_csr_index;
    logic next_csr_rd_req;
    logic next_csr_wr_req;
    logic [HPB_DATA_W-1:0] next_csr_wr_data;
    logic next_counter_snap;
    logic next_rx_fifo_pop;
    logic [HPB_FIFO_IDX_W-1:0] next_fifo_index;
    logic next_tx_fifo_push;
    logic [HPB_DATA_W-1:0] next_tx_fifo_data;
    logic next_burst_overrun;
    logic read_on;
    logic write_on;
    logic [HPB_ADDR_W-1:0] addr_s;
    logic [HPB_DATA_W-1:0] data_s;

    // strobes and fifo select are asynchronous pins, each filtered before use
    hpb_sync u_sync_cs (.clock(clock), .rst_b(rst_b), .pin(host_select_n), .rst_value(1'b1), .level(cs_n_s));
    hpb_sync u_sync_rd (.clock(clock), .rst_b(rst_b), .pin(read_strobe_n), .rst_value(1'b1), .level(rd_n_s));
    hpb_sync u_sync_wr (.clock(clock), .rst_b(rst_b), .pin(write_strobe_n), .rst_value(1'b1), .level(wr_n_s));
    hpb_sync u_sync_fs (.clock(clock), .rst_b(rst_b), .pin(fifo_sel), .rst_value(1'b0), .level(fsel_s));

    // address and data pins ride the same three stages, so they stay aligned with the strobes
    for (genvar gi = 0; gi < HPB_ADDR_W; gi++) begin : g_addr_sync
        hpb_sync u_sync_a (.clock(clock), .rst_b(rst_b), .pin(host_addr[gi]), .rst_value(1'b0),
            .level(addr_s[gi]));
    end
    for (genvar gd = 0; gd < HPB_DATA_W; gd++) begin : g_data_sync
        hpb_sync u_sync_d (.clock(clock), .rst_b(rst_b), .pin(host_data_in[gd]), .rst_value(1'b0),
            .level(data_s[gd]));
    end

    // access framing: order of strobe edges does not matter
    assign read_on = !cs_n_s && !rd_n_s;
    assign write_on = !cs_n_s && !wr_n_s;

    // access sequencer and datapath next values
    always_comb begin
        next_state = state;
        next_cur_addr = cur_addr;
        next_wr_hold = wr_hold;
        next_word_count = word_count;
        next_is_fifo = is_fifo;
        next_data_out = host_data_out;
        next_data_oe = 1'b0;
        next_csr_index = csr_index;
        next_csr_rd_req = 1'b0;
        next_csr_wr_req = 1'b0;
        next_csr_wr_data = csr_wr_data;
        next_counter_snap = 1'b0;
        next_rx_fifo_pop = 1'b0;
        next_fifo_index = fifo_index;
        next_tx_fifo_push = 1'b0;
        next_tx_fifo_data = tx_fifo_data;
        next_burst_overrun = 1'b0;
        case (state)
            HPB_IDLE: begin
                if (read_on) begin
                    next_state = HPB_READ;
                    next_cur_addr = addr_s;
                    next_is_fifo = fsel_s;
                    next_word_count = 5'h01;
                    next_counter_snap = 1'b1;
                    if (fsel_s) begin
                        next_rx_fifo_pop = 1'b1;
                        next_fifo_index = addr_s[HPB_FIFO_IDX_W-1:0];
                    end else begin
                        next_csr_rd_req = 1'b1;
                        next_csr_index = addr_s[HPB_CSR_IDX_W-1:0];
                    end
                end else if (write_on) begin
                    next_state = HPB_WRITE;
                    next_is_fifo = fsel_s;
                    next_cur_addr = addr_s;
                end
            end
            HPB_READ: begin
                next_data_oe = 1'b1;
                // fifo word or register word on all sixteen lines
                next_data_out = is_fifo ? rx_fifo_data : csr_rd_data;
                if (!read_on) begin
                    next_state = HPB_GAP;
                    next_data_oe = 1'b0;
                end else if (addr_s != cur_addr) begin
                    next_cur_addr = addr_s;
                    if (is_fifo) begin
                        next_rx_fifo_pop = 1'b1;
                        next_fifo_index = addr_s[HPB_FIFO_IDX_W-1:0];
                    end else if (word_count < HPB_BURST_MAX) begin
                        next_csr_rd_req = 1'b1;
                        next_csr_index = addr_s[HPB_CSR_IDX_W-1:0];
                        next_word_count = word_count + 5'h01;
                    end else begin
                        next_burst_overrun = 1'b1;
                    end
                end
            end
            HPB_WRITE: begin
                // data is taken late so setup before the rising strobe is honoured
                next_wr_hold = data_s;
                if (!write_on) begin
                    next_state = HPB_GAP;
                    if (is_fifo) begin
                        next_tx_fifo_push = 1'b1;
                        next_tx_fifo_data = wr_hold;
                    end else begin
                        next_csr_wr_req = 1'b1;
                        next_csr_wr_data = wr_hold;
                        next_csr_index = cur_addr[HPB_CSR_IDX_W-1:0];
                    end
                end
            end
            HPB_GAP: begin
                // one idle cycle; host spacing covers the rest
                next_state = HPB_IDLE;
            end
            default: begin
                next_state = HPB_IDLE;
            end
        endcase
    end

    // state and registered outputs, nothing but the next values here
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state <= HPB_IDLE;
            cur_addr <= HPB_ADDR_RST;
            wr_hold <= HPB_DATA_RST;
            word_count <= HPB_COUNT_RST;
            is_fifo <= 1'b0;
            host_data_out <= HPB_DATA_RST;
            host_data_oe <= 1'b0;
            csr_index <= '0;
            csr_rd_req <= 1'b0;
            csr_wr_req <= 1'b0;
            csr_wr_data <= HPB_DATA_RST;
            counter_snap <= 1'b0;
            rx_fifo_pop <= 1'b0;
            fifo_index <= '0;
            tx_fifo_push <= 1'b0;
            tx_fifo_data <= HPB_DATA_RST;
            burst_overrun <= 1'b0;
        end else begin
            state <= next_state;
            cur_addr <= next_cur_addr;
            wr_hold <= next_wr_hold;
            word_count <= next_word_count;
            is_fifo <= next_is_fifo;
            host_data_out <= next_data_out;
            host_data_oe <= next_data_oe;
            csr_index <= next_csr_index;
            csr_rd_req <= next_csr_rd_req;
            csr_wr_req <= next_csr_wr_req;
            csr_wr_data <= next_csr_wr_data;
            counter_snap <= next_counter_snap;
            rx_fifo_pop <= next_rx_fifo_pop;
            fifo_index <= next_fifo_index;
            tx_fifo_push <= next_tx_fifo_push;
            tx_fifo_data <= next_tx_fifo_data;
            burst_overrun <= next_burst_overrun;
        end
    end
endmodule : hpb_port

// *** hpb_port_asserts.sv ***
// pin-level checks of the host bus port
`timescale 1ns/1ps
module hpb_port_asserts (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [hpb_pkg::HPB_ADDR_W-1:0] host_addr,
    input wire logic host_data_oe,
    input wire logic csr_rd_req,
    input wire logic csr_wr_req,
    input wire logic counter_snap,
    input wire logic rx_fifo_pop,
    input wire logic [hpb_pkg::HPB_FIFO_IDX_W-1:0] fifo_index,
    input wire logic tx_fifo_push,
    input wire logic burst_overrun
);
    import hpb_pkg::*;
    logic [1:0] addr_low;
    // word select on the address pins one edge before a pop
    always_ff @(posedge clock) addr_low <= host_addr[1:0];
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_snap_on_read: assert property (counter_snap |-> csr_rd_req || rx_fifo_pop) else $error("snap off read");
    a_data_follows: assert property (csr_rd_req || rx_fifo_pop |-> ##1 host_data_oe) else $error("no data");
    a_read_in_frame: assert property (csr_rd_req || rx_fifo_pop |-> !$past(read_strobe_n, 3)) else $error("no frame");
    a_oe_released: assert property (read_strobe_n [*8] |-> !host_data_oe) else $error("oe stuck");
    a_write_ends: assert property (write_strobe_n [*8] |-> !(tx_fifo_push || csr_wr_req)) else $error("late write");
    a_one_target: assert property ($onehot0({tx_fifo_push, csr_wr_req, rx_fifo_pop, csr_rd_req})) else $error("two targets");
    a_overrun_quiet: assert property (burst_overrun |-> !(csr_rd_req || rx_fifo_pop)) else $error("word 17 read");
    a_fifo_word_sel: assert property (rx_fifo_pop |-> fifo_index == addr_low) else $error("bad index");
endmodule : hpb_port_asserts
bind hpb_port hpb_port_asserts u_chk (.clock, .rst_b, .read_strobe_n, .write_strobe_n, .host_addr, .host_data_oe,
    .csr_rd_req, .csr_wr_req, .counter_snap, .rx_fifo_pop, .fifo_index, .tx_fifo_push, .burst_overrun);

// *** hpb_port_tb.sv ***
// self-checking bench for the host bus port
`timescale 1ns/1ps
module hpb_port_tb;
    import hpb_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic host_select_n, read_strobe_n, write_strobe_n, fifo_sel, host_data_oe, csr_rd_req, csr_wr_req;
    logic counter_snap, rx_fifo_pop, tx_fifo_push, burst_overrun;
    logic [HPB_CSR_IDX_W-1:0] seen_index;
    logic [HPB_FIFO_IDX_W-1:0] seen_fidx;
    logic [HPB_ADDR_W-1:0] host_addr;
    logic [HPB_DATA_W-1:0] host_data_in, host_data_out, csr_wr_data, tx_fifo_data, seen_data;
    logic [HPB_DATA_W-1:0] csr_rd_data = 16'h0000;
    logic [HPB_DATA_W-1:0] rx_fifo_data = 16'h0000;
    logic [HPB_CSR_IDX_W-1:0] csr_index;
    logic [HPB_FIFO_IDX_W-1:0] fifo_index;
    int n_fail = 0, total_checks = 0, n_pop = 0, n_snap = 0, n_push = 0, n_wr = 0, n_ovr = 0;
    initial forever #20 clock = ~clock;
    hpb_host_model u_host (.clock, .host_select_n, .read_strobe_n, .write_strobe_n, .fifo_sel, .host_addr,
        .host_data_in);
    hpb_port u_dut (.clock, .rst_b, .host_select_n, .read_strobe_n, .write_strobe_n, .fifo_sel, .host_addr,
        .host_data_in, .host_data_out, .host_data_oe, .csr_index, .csr_rd_req, .csr_wr_req, .csr_wr_data,
        .counter_snap, .csr_rd_data, .rx_fifo_pop, .fifo_index, .rx_fifo_data, .tx_fifo_push, .tx_fifo_data,
        .burst_overrun);
    // register file and receive fifo answer on the falling edge after a request, half a cycle later
    always @(negedge clock) begin
        if (csr_rd_req) csr_rd_data <= 16'hC300 | {11'h000, csr_index};
        if (rx_fifo_pop) rx_fifo_data <= 16'h5A00 + 16'(n_pop);
        if (rx_fifo_pop) n_pop <= n_pop + 1;
        if (counter_snap) n_snap <= n_snap + 1;
        if (tx_fifo_push) n_push <= n_push + 1;
        if (csr_wr_req) n_wr <= n_wr + 1;
        if (tx_fifo_push || csr_wr_req) seen_data <= tx_fifo_push ? tx_fifo_data : csr_wr_data;
        if (burst_overrun) n_ovr <= n_ovr + 1;
        if (csr_wr_req) seen_index <= csr_index;
        if (rx_fifo_pop) seen_fidx <= fifo_index;
    end
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    // single register read ended by the select strobe
    task automatic t_single_read;
        u_host.start(1'b0, 1'b0, 7'h53, 16'h0000);
        chk("oe", {15'h0000, host_data_oe}, 16'h0001);
        chk("csr read", host_data_out, 16'hC313);
        u_host.stop(1'b1);
        chk("oe off", {15'h0000, host_data_oe}, 16'h0000);
    endtask : t_single_read
    // normal burst asks one word past the limit, ended by the read strobe
    task automatic t_csr_burst;
        u_host.start(1'b0, 1'b0, 7'h00, 16'h0000);
        for (int i = 0; i < 17; i++) begin
            if (i > 0) u_host.next_addr(7'(i));
            if (i < 16) chk("burst word", host_data_out, 16'hC300 | 16'(i));
            if (i == 15) chk("early overrun", 16'(n_ovr), 16'h0000);
        end
        chk("overrun", 16'(n_ovr), 16'h0001);
        chk("kept word", host_data_out, 16'hC30F);
        u_host.stop(1'b0);
        chk("burst end", {15'h0000, host_data_oe}, 16'h0000);
    endtask : t_csr_burst
    // fifo-direct burst of 20 words, upper address bits scrambled
    task automatic t_fifo_burst;
        logic [6:0] a;
        u_host.start(1'b0, 1'b1, 7'h7C, 16'h0000);
        for (int i = 0; i < 20; i++) begin
            a = (i > 0) ? 7'(i * 37 + 3) : 7'h7C;
            if (i > 0) u_host.next_addr(a);
            chk("fifo word", host_data_out, 16'h5A00 + 16'(i));
            chk("fifo index", {14'h0000, seen_fidx}, {14'h0000, a[1:0]});
        end
        chk("no limit", 16'(n_ovr), 16'h0001);
        u_host.stop(1'b1);
    endtask : t_fifo_burst
    // register write, then fifo-direct write
    task automatic t_writes;
        u_host.start(1'b1, 1'b0, 7'h65, 16'h1234);
        u_host.stop(1'b0);
        chk("csr data", seen_data, 16'h1234);
        chk("csr writes", 16'(n_wr), 16'h0001);
        chk("csr wr index", {11'h000, seen_index}, 16'h0005);
        u_host.start(1'b1, 1'b1, 7'h66, 16'hBEEF);
        u_host.stop(1'b1);
        chk("tx data", seen_data, 16'hBEEF);
        chk("tx pushes", 16'(n_push), 16'h0001);
        chk("snaps", 16'(n_snap), 16'h0003);
    endtask : t_writes
    initial begin
        repeat (12) @(negedge clock);
        rst_b = 1'b1;
        t_single_read();
        t_csr_burst();
        t_fifo_burst();
        t_writes();
        finish_test();
    end
    // hang guard, far beyond the roughly 380 cycles of traffic
    initial begin
        repeat (5000) @(posedge clock);
        n_fail++;
        finish_test();
    end
endmodule : hpb_port_tb

// *** hpb_sync.sv ***
`timescale 1ns/1ps
// three-stage synchroniser with agreement filter for one pin
module hpb_sync (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic pin,
    input wire logic rst_value,
    output logic level
);
    import hpb_pkg::*;

    logic [HPB_SYNC_STAGES-1:0] stage;
    logic [HPB_SYNC_STAGES-1:0] next_stage;
    logic next_level;

    // shift in; level only moves once stages two and three agree
    always_comb begin
        next_stage = {stage[HPB_SYNC_STAGES-2:0], pin};
        next_level = (stage[1] == stage[2]) ? stage[2] : level;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            stage <= {HPB_SYNC_STAGES{rst_value}};
            level <= rst_value;
        end else begin
            stage <= next_stage;
            level <= next_level;
        end
    end
endmodule : hpb_sync
